// ---- shared/hdmc_cfg.svh ----
// Offsets, field positions, reset values and timing counts
`ifndef HDMC_CFG_SVH
`define HDMC_CFG_SVH
`define HDMC_ADDR_DRIVE_MODE_CFG 8'h1D
`define HDMC_POS_NG_LVL          6
`define HDMC_POS_ROTOR_OL        5
`define HDMC_POS_SUPPLY_OFF      4
`define HDMC_POS_LIVE_UNSIGNED   3
`define HDMC_POS_UPDATE_RATE     2
`define HDMC_POS_INPUT_ANALOG    1
`define HDMC_POS_RES_OL          0
`define HDMC_RST_DRIVE_MODE_CFG  8'hA0
`define HDMC_NG_LVL_2PCT         8'h06
`define HDMC_NG_LVL_4PCT         8'h0B
`define HDMC_NG_LVL_8PCT         8'h15
`define HDMC_PWM_DIV_HALF        6'h3F
`define HDMC_EXT_INPUT_MODE      3'h3
`define HDMC_SUPPLY_NOMINAL      8'h80
`endif

// ---- shared/hdmc_pkg.sv ----
// Types for the drive mode configuration block
`default_nettype none
package hdmc_pkg;
  typedef struct packed {
    logic [1:0] noise_gate_level;
    logic       rotor_open_loop_sel;
    logic       supply_scaling_off;
    logic       live_data_unsigned;
    logic       resonant_update_rate;
    logic       input_analog_sel;
    logic       resonant_open_loop_sel;
  } hdmc_cfg_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hdmc_req_t;

  typedef enum logic [1:0] {
    HDMC_IDLE = 2'b00,
    HDMC_PLAY = 2'b01,
    HDMC_STOP = 2'b11
  } hdmc_state_t;
endpackage : hdmc_pkg
`default_nettype wire

// ---- logic/hdmc_drive_mode.sv ----
// Drive mode configuration register and the drive path it steers
// Function
// - Two-bit noise gate: off, 2%, 4%, 8% of input; resets to 4%.
// - Rotating-mass control scheme bit: 0 closed, 1 open loop; resets open.
// - Closed-loop rotating mass uses overdrive and braking; open loop stays.
// - Supply compensation disable bit: 0 active, 1 off; resets to 0.
// - Compensation holds drive level over supply; off means no scaling.
// - Live playback data format: 0 signed, 1 unsigned; resets signed.
// - Open-loop resonant amplitude update once (0) or twice (1) per cycle.
// - In mode 3 input bit selects PWM (0) or analog (1) pin read.
// - PWM input: amplitude follows duty cycle of the external pin.
// - Analog input: amplitude follows level on the external pin.
// - Resonant drive: 0 auto-resonance, 1 open loop at chosen frequency.
// - Open loop with PWM input: commutation is PWM frequency over 128.
// - Live, library and audio modes take frequency from 7-bit period.
// - Open loop with analog input is unsupported; software avoids it.
// - Actuator type: 0 rotating mass settings, 1 resonant settings.
// - Configuration register sits at register address 0x1D.
`timescale 1ns/1ps
`default_nettype none
`include "hdmc_cfg.svh"
module hdmc_drive_mode #(
  parameter int unsigned OL_TICK_CYC = 2500
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  // Register port
  input  wire hdmc_pkg::hdmc_req_t reg_req,
  output logic [7:0]               reg_rdata,
  // Playback control
  input  wire logic [2:0]          op_mode,
  input  wire logic                actuator_type_sel,
  input  wire logic                playback_go,
  input  wire logic [6:0]          open_loop_period,
  input  wire logic [7:0]          live_playback,
  input  wire logic [7:0]          library_level,
  // External input and supply
  input  wire logic                external_input_pin,
  input  wire logic [7:0]          analog_level,
  input  wire logic [7:0]          supply_level,
  // Drive outputs
  output logic [7:0]               drive_amplitude,
  output logic                     commutation_phase,
  output logic                     overdrive_brake_en,
  output logic                     resonance_track_en,
  output logic                     playing
);
  import hdmc_pkg::*;

  hdmc_cfg_t   cfg_q;
  hdmc_cfg_t   act_q;
  hdmc_state_t state_q;
  logic [2:0]  pin_sync_q;
  logic [15:0] per_cnt_q;
  logic [15:0] high_cnt_q;
  logic [7:0]  duty_q;
  logic [5:0]  edge_cnt_q;
  logic        pwm_comm_q;
  logic [22:0] ol_cnt_q;
  logic        ol_comm_q;
  logic        comm_prev_q;
  logic        ext_mode;
  logic        pin_rise;
  logic        pin_level;
  logic        res_ol_eff;
  logic        comm_src;
  logic        upd_strobe;
  logic [7:0]  raw_amp;
  logic [7:0]  gate_lvl;
  logic [7:0]  gated_amp;
  logic [23:0] scaled;
  logic [7:0]  comp_amp;
  logic [22:0] ol_limit;

  // Register write and read-back
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= `HDMC_RST_DRIVE_MODE_CFG;
    end else if (reg_req.wr && reg_req.addr == `HDMC_ADDR_DRIVE_MODE_CFG) begin
      cfg_q <= reg_req.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      // Other addresses belong to neighbouring registers; answer zero
      reg_rdata <= (reg_req.addr == `HDMC_ADDR_DRIVE_MODE_CFG) ?
                   cfg_q : 8'h00;
    end
  end

  // Playback sequencing; settings are captured only at start
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= HDMC_IDLE;
      act_q   <= `HDMC_RST_DRIVE_MODE_CFG;
    end else begin
      case (state_q)
        HDMC_IDLE: begin
          if (playback_go) begin
            act_q   <= cfg_q;
            state_q <= HDMC_PLAY;
          end
        end
        HDMC_PLAY: begin
          if (!playback_go) begin
            state_q <= HDMC_STOP;
          end
        end
        HDMC_STOP: state_q <= HDMC_IDLE;
        default:   state_q <= HDMC_IDLE;
      endcase
    end
  end

  assign playing = (state_q == HDMC_PLAY);

  // Pin crosses in via three stages; level accepted when last two agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_sync_q <= 3'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], external_input_pin};
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_level <= 1'b0;
    end else if (pin_sync_q[1] == pin_sync_q[2]) begin
      pin_level <= pin_sync_q[2];
    end
  end

  logic pin_level_prev_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_level_prev_q <= 1'b0;
    end else begin
      pin_level_prev_q <= pin_level;
    end
  end
  assign pin_rise = pin_level && !pin_level_prev_q;

  // Duty measurement over one PWM period; division kept out of hot path
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      per_cnt_q  <= 16'h0000;
      high_cnt_q <= 16'h0000;
      duty_q     <= 8'h00;
    end else if (pin_rise) begin
      if (per_cnt_q != 16'h0000) begin
        duty_q <= 8'(({high_cnt_q, 8'h00} - {8'h00, high_cnt_q})
                      / {8'h00, per_cnt_q});
      end
      per_cnt_q  <= 16'h0001;
      high_cnt_q <= 16'h0001;
    end else begin
      if (per_cnt_q != 16'hFFFF) begin
        per_cnt_q <= per_cnt_q + 16'h0001;
      end
      if (pin_level && high_cnt_q != 16'hFFFF) begin
        high_cnt_q <= high_cnt_q + 16'h0001;
      end
    end
  end

  // PWM frequency divided by 128: toggle every 64 rising edges
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_cnt_q <= 6'h00;
      pwm_comm_q <= 1'b0;
    end else if (pin_rise) begin
      edge_cnt_q <= edge_cnt_q + 6'h01;
      if (edge_cnt_q == `HDMC_PWM_DIV_HALF) begin
        pwm_comm_q <= ~pwm_comm_q;
      end
    end
  end

  // Period field sets each half cycle in ticks of OL_TICK_CYC cycles
  assign ol_limit = 23'(open_loop_period) * 23'(OL_TICK_CYC);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ol_cnt_q  <= 23'h000000;
      ol_comm_q <= 1'b0;
    end else if (!playing || ol_limit == 23'h000000) begin
      // Each playback starts its phase fresh, not from the last one
      ol_cnt_q  <= 23'h000000;
      ol_comm_q <= 1'b0;
    end else if (ol_cnt_q + 23'h000001 >= ol_limit) begin
      ol_cnt_q  <= 23'h000000;
      ol_comm_q <= ~ol_comm_q;
    end else begin
      ol_cnt_q <= ol_cnt_q + 23'h000001;
    end
  end

  assign ext_mode = (op_mode == `HDMC_EXT_INPUT_MODE);
  // Analog with open loop is unsupported; fall back to auto-resonance
  assign res_ol_eff = act_q.resonant_open_loop_sel &&
                      !(ext_mode && act_q.input_analog_sel);
  assign comm_src = (ext_mode && !act_q.input_analog_sel) ?
                    pwm_comm_q : ol_comm_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      commutation_phase <= 1'b0;
      comm_prev_q       <= 1'b0;
    end else begin
      commutation_phase <= actuator_type_sel && res_ol_eff && playing &&
                           comm_src;
      comm_prev_q       <= commutation_phase;
    end
  end

  // Once per cycle on rising phase, or on both phase edges
  assign upd_strobe = act_q.resonant_update_rate ?
                      (commutation_phase != comm_prev_q) :
                      (commutation_phase && !comm_prev_q);

  // Amplitude source selection
  always_comb begin
    if (ext_mode) begin
      raw_amp = act_q.input_analog_sel ? analog_level : duty_q;
    end else if (act_q.live_data_unsigned) begin
      raw_amp = live_playback;
    end else begin
      // Signed data maps to offset binary so zero sits mid-scale
      raw_amp = {~live_playback[7], live_playback[6:0]};
    end
    if (op_mode != `HDMC_EXT_INPUT_MODE && op_mode == 3'h0) begin
      raw_amp = library_level;
    end
  end

  // Noise gate only applies to pin-driven amplitudes
  always_comb begin
    case (act_q.noise_gate_level)
      2'h1:    gate_lvl = `HDMC_NG_LVL_2PCT;
      2'h2:    gate_lvl = `HDMC_NG_LVL_4PCT;
      2'h3:    gate_lvl = `HDMC_NG_LVL_8PCT;
      default: gate_lvl = 8'h00;
    endcase
  end
  assign gated_amp = (ext_mode && raw_amp < gate_lvl) ? 8'h00 : raw_amp;

  // Scale by nominal over measured supply, saturating at full scale
  // Wide enough that full scale over a low supply cannot wrap
  assign scaled = (supply_level == 8'h00) ? 24'hFFFFFF :
                  ((24'({gated_amp, 8'h00}) / 24'(supply_level)) *
                   24'(`HDMC_SUPPLY_NOMINAL)) >> 8;
  assign comp_amp = act_q.supply_scaling_off ?
                    gated_amp :
                    (scaled > 24'h0000FF ? 8'hFF : scaled[7:0]);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_amplitude <= 8'h00;
    end else if (!playing) begin
      drive_amplitude <= 8'h00;
    end else if (!actuator_type_sel || !res_ol_eff || upd_strobe) begin
      drive_amplitude <= comp_amp;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      overdrive_brake_en <= 1'b0;
      resonance_track_en <= 1'b0;
    end else begin
      overdrive_brake_en <= playing && !actuator_type_sel &&
                            !act_q.rotor_open_loop_sel;
      resonance_track_en <= playing && actuator_type_sel &&
                            !res_ol_eff;
    end
  end
endmodule : hdmc_drive_mode
`default_nettype wire

// ---- tb/hdmc_checker.sv ----
// Assertion checker for the drive mode configuration block
`timescale 1ns/1ps
`default_nettype none
`include "hdmc_cfg.svh"
module hdmc_checker
  import hdmc_pkg::*;
(
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                rst_b,
  // Register port
  input wire hdmc_pkg::hdmc_req_t reg_req,
  input wire logic [7:0]          reg_rdata,
  // Playback
  input wire logic                playback_go,
  input wire logic [7:0]          drive_amplitude,
  input wire logic                overdrive_brake_en,
  input wire logic                resonance_track_en,
  input wire logic                playing
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  localparam logic [7:0] CFG_ADDR = `HDMC_ADDR_DRIVE_MODE_CFG;
  sequence s_wr_rd;
    (reg_req.wr && reg_req.addr == CFG_ADDR) ##1
    (!reg_req.wr && !reg_req.rd) ##1
    (reg_req.rd && !reg_req.wr && reg_req.addr == CFG_ADDR);
  endsequence
  sequence s_idle_go;
    (!playing) [*3] ##0 $rose(playback_go);
  endsequence
  a_reset_clear: assert property ($rose(rst_b) |->
    reg_rdata == 8'h00 && !playing) else $error("outputs not clear");
  a_write_readback: assert property (s_wr_rd |=>
    reg_rdata == $past(reg_req.wdata, 3)) else $error("readback wrong");
  a_other_addr: assert property (reg_req.rd && reg_req.addr != CFG_ADDR
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_idle_quiet: assert property ((!playing) [*2] |->
    drive_amplitude == 8'h00 && !overdrive_brake_en && !resonance_track_en)
    else $error("outputs active while idle");
  a_go_start: assert property (s_idle_go |=> playing)
    else $error("playback did not start");
  a_go_stop: assert property (playing && !playback_go |=> !playing)
    else $error("playback did not stop");
  a_mode_excl: assert property (overdrive_brake_en |->
    !resonance_track_en) else $error("both actuator schemes active");
endmodule : hdmc_checker
bind hdmc_drive_mode hdmc_checker hdmc_checker_i (
  .core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .playback_go(playback_go),
  .drive_amplitude(drive_amplitude), .overdrive_brake_en(overdrive_brake_en),
  .resonance_track_en(resonance_track_en), .playing(playing));
`default_nettype wire

// ---- tb/tb.sv ----
// Testbench for the drive mode configuration block
`timescale 1ns/1ps
`default_nettype none
`include "hdmc_cfg.svh"
module tb;
  import hdmc_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_b = 1'b0;
  hdmc_req_t  reg_req = '0;
  logic [7:0] reg_rdata, drive_amplitude, lvl = 8'h00, sup = 8'h80;
  logic [2:0] op_mode = 3'h0;
  logic       act = 1'b0, go = 1'b0, pin = 1'b0;
  logic       phase, od_en, tr_en, playing;
  logic [2:0] pwm_cnt = 3'h0;
  int         errors = 0, num_checks = 0;
  always #20 core_clk = ~core_clk;
  // PWM at 128 times the resonant rate: 8-cycle period, half duty
  always @(posedge core_clk) begin
    pwm_cnt <= pwm_cnt + 3'h1;
    pin     <= (pwm_cnt < 3'h4);
  end
  hdmc_drive_mode #(.OL_TICK_CYC(2)) hdmc_drive_mode_i (
    .core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .op_mode(op_mode), .actuator_type_sel(act),
    .playback_go(go), .open_loop_period(7'h05), .live_playback(lvl),
    .library_level(lvl), .external_input_pin(pin), .analog_level(lvl),
    .supply_level(sup), .drive_amplitude(drive_amplitude),
    .commutation_phase(phase), .overdrive_brake_en(od_en),
    .resonance_track_en(tr_en), .playing(playing));
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk) reg_req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk) reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk) reg_req <= '0;
    @(negedge core_clk) check(reg_rdata, exp);
  endtask : rd
  // Config is captured at start, so each case writes before raising go
  task automatic play(input logic [7:0] cfg, input logic a, input logic [2:0] m,
      input logic [7:0] l, input logic [7:0] s, input logic [7:0] amp,
      input logic od, input logic tr);
    int n;
    wr(`HDMC_ADDR_DRIVE_MODE_CFG, cfg);
    @(posedge core_clk) begin
      act <= a; op_mode <= m; lvl <= l; sup <= s;
    end
    @(posedge core_clk) go <= 1'b1;
    for (n = 0; n < 10 && playing !== 1'b1; n++) @(negedge core_clk);
    if (n == 10) begin
      errors++;
      complete_run();
    end
    // Open loop updates amplitude only after the first phase rise
    repeat (14) @(posedge core_clk);
    @(negedge core_clk) check(drive_amplitude, amp);
    check({5'h00, phase, od_en, tr_en}, {5'h00,
          a && cfg[0] && !(m == `HDMC_EXT_INPUT_MODE && cfg[1]), od, tr});
    @(posedge core_clk) go <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : play
  // Measures one half cycle of the commutation phase in open loop
  task automatic half_period(input logic [7:0] cfg, input logic [2:0] m,
      input int exp);
    int   n;
    logic p;
    wr(`HDMC_ADDR_DRIVE_MODE_CFG, cfg);
    @(posedge core_clk) begin
      act     <= 1'b1;
      op_mode <= m;
    end
    @(posedge core_clk) go <= 1'b1;
    repeat (4) @(negedge core_clk);
    for (int k = 0; k < 2; k++) begin
      p = phase;
      for (n = 0; n < 1200 && phase === p; n++) @(negedge core_clk);
      if (n == 1200) begin
        errors++;
        complete_run();
      end
    end
    check(8'(n >> 8), 8'(exp >> 8));
    check(8'(n), 8'(exp));
    @(posedge core_clk) go <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : half_period
  initial begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(`HDMC_ADDR_DRIVE_MODE_CFG, `HDMC_RST_DRIVE_MODE_CFG);
    for (int i = 0; i < 8; i++) begin
      wr(`HDMC_ADDR_DRIVE_MODE_CFG, 8'h01 << i);
      rd(`HDMC_ADDR_DRIVE_MODE_CFG, 8'h01 << i);
    end
    wr(`HDMC_ADDR_DRIVE_MODE_CFG, 8'h5A);
    wr(8'h1C, 8'hFF);
    rd(`HDMC_ADDR_DRIVE_MODE_CFG, 8'h5A);
    rd(8'h1C, 8'h00);
    play(8'h20, 1'b0, 3'h0, 8'h50, 8'h80, 8'h50, 1'b0, 1'b0);
    play(8'h00, 1'b0, 3'h0, 8'h50, 8'h80, 8'h50, 1'b1, 1'b0);
    play(8'h20, 1'b0, 3'h0, 8'h50, 8'h40, 8'hA0, 1'b0, 1'b0);
    play(8'h20, 1'b0, 3'h0, 8'hC0, 8'h40, 8'hFF, 1'b0, 1'b0);
    play(8'h30, 1'b0, 3'h0, 8'h50, 8'h40, 8'h50, 1'b0, 1'b0);
    play(8'h00, 1'b1, 3'h0, 8'h50, 8'h80, 8'h50, 1'b0, 1'b1);
    play(8'h01, 1'b1, 3'h0, 8'h50, 8'h80, 8'h50, 1'b0, 1'b0);
    play(8'h22, 1'b0, 3'h3, 8'h60, 8'h80, 8'h60, 1'b0, 1'b0);
    play(8'h62, 1'b0, 3'h3, 8'h05, 8'h80, 8'h00, 1'b0, 1'b0);
    play(8'hE2, 1'b0, 3'h3, 8'h14, 8'h80, 8'h00, 1'b0, 1'b0);
    play(8'h20, 1'b0, 3'h1, 8'h10, 8'h80, 8'h90, 1'b0, 1'b0);
    play(8'h28, 1'b0, 3'h1, 8'h10, 8'h80, 8'h10, 1'b0, 1'b0);
    play(8'h20, 1'b0, 3'h3, 8'h00, 8'h80, 8'h7F, 1'b0, 1'b0);
    play(8'h03, 1'b1, 3'h3, 8'h60, 8'h80, 8'h60, 1'b0, 1'b1);
    half_period(8'h01, 3'h1, 10);
    half_period(8'h01, 3'h3, 512);
    complete_run();
  end
endmodule : tb
`default_nettype wire
